// ==== shared/pms_map.svh ====
// register offsets, field positions and reset values of the standby control block
// assumes inclusion by the package and the rtl files
`ifndef PMS_MAP_SVH
`define PMS_MAP_SVH

`define PMS_STANDBY_CTRL_OFFSET 12'h000
`define PMS_STANDBY_CTRL_RESET 8'h00
`define PMS_SERIAL_BIT 7
`define PMS_ITIMER_BIT 4
`define PMS_MFTIMER_BIT 1
`define PMS_WRITABLE_MASK 8'h92
`define PMS_ADDR_WIDTH 12
`define PMS_RESP_OKAY 2'b00
`define PMS_RESP_SLVERR 2'b10

`endif

// ==== shared/pms_pkg.sv ====
// types shared by the standby control block
// assumes pms_map.svh sits beside it on the include path
`include "pms_map.svh"

package pms_pkg;

  // standby requests to the three covered peripherals
  typedef struct packed {
    logic serial;
    logic itimer;
    logic mftimer;
  } pms_standby_t;

  // write address and data held by the slave until both have arrived
  typedef struct packed {
    logic [`PMS_ADDR_WIDTH-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } pms_wreq_t;

endpackage

// ==== rtl/pms_ctrl_reg.sv ====
// the standby control register itself, with reserved bits forced to zero
// assumes a one-cycle write strobe from the bus slave on the same clock
`timescale 1ns/100ps
`include "pms_map.svh"

module pms_ctrl_reg
  import pms_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write side
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // register image and decoded requests
  output logic [7:0] value,
  output pms_standby_t standby
);

  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;

  // only the three documented bits can ever hold a one
  assign ctrl_d = wr_en ? (wr_data & `PMS_WRITABLE_MASK) : ctrl_q;

  // all bits clear at reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_q <= `PMS_STANDBY_CTRL_RESET;
    else
      ctrl_q <= ctrl_d;
  end

  assign value = ctrl_q;
  // a cleared bit drops the request at once, so the module resumes on its own settings
  assign standby.serial = ctrl_q[`PMS_SERIAL_BIT];
  assign standby.itimer = ctrl_q[`PMS_ITIMER_BIT];
  assign standby.mftimer = ctrl_q[`PMS_MFTIMER_BIT];

endmodule // pms_ctrl_reg

// ==== rtl/pms_standby_ctrl.sv ====
// axi4-lite slave holding the peripheral standby control register
// assumes one clock domain; the peripherals sample the standby outputs on aclk
`timescale 1ns/100ps
`include "pms_map.svh"

// Operation
// - bit 7 places second serial interface in standby
// - bit 4 places interval timer in standby
// - bit 1 places multifunction timer in standby
// - bits 6,5,3,2 always read zero
// - bit 0 always reads zero
module pms_standby_ctrl
  import pms_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [`PMS_ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address channel
  input wire logic [`PMS_ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // standby requests to the peripherals
  output logic second_serial_standby_bit,
  output logic interval_timer_standby_bit,
  output logic multifunction_timer_standby_bit
);

  // the low two address bits pick a byte lane, so only the word address is compared
  function automatic logic hits_ctrl(input logic [`PMS_ADDR_WIDTH-1:0] a);
    logic [`PMS_ADDR_WIDTH-1:0] base;
    base = `PMS_STANDBY_CTRL_OFFSET;
    hits_ctrl = (a[`PMS_ADDR_WIDTH-1:2] == base[`PMS_ADDR_WIDTH-1:2]);
  endfunction

  // response code for a decoded access, shared by the write and the read answer
  function automatic logic [1:0] resp_for(input logic hit);
    resp_for = hit ? `PMS_RESP_OKAY : `PMS_RESP_SLVERR;
  endfunction

  // write address and data held until their partner arrives
  logic aw_have_q;
  logic aw_have_d;
  logic w_have_q;
  logic w_have_d;
  pms_wreq_t wreq_q;
  pms_wreq_t wreq_d;

  // write response
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;

  // read response
  logic rvalid_q;
  logic rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;

  // register image and decoded standby requests
  logic [7:0] ctrl_value;
  pms_standby_t standby;

  // channel handshakes
  logic aw_fire;
  logic w_fire;
  logic b_done;
  logic ar_fire;
  logic r_done;
  // write decode
  logic aw_now;
  logic w_now;
  logic [`PMS_ADDR_WIDTH-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_commit;
  logic wr_hit;
  logic reg_wr;
  // read decode
  logic rd_hit;
  logic [31:0] rd_word;

  // each channel moves one item at the edge where its valid and ready meet
  // all decode is continuous; the clocked blocks below only load next values
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign b_done = bvalid_q && s_axi_bready;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign r_done = rvalid_q && s_axi_rready;

  // readies depend on state only, so no path runs from a valid back to its ready
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;

  // address and data are taken in either order; a held half stands in for the live one
  assign aw_now = aw_have_q || aw_fire;
  assign w_now = w_have_q || w_fire;
  assign wr_addr = aw_have_q ? wreq_q.addr : s_axi_awaddr;
  assign wr_data = w_have_q ? wreq_q.data : s_axi_wdata;
  assign wr_strb = w_have_q ? wreq_q.strb : s_axi_wstrb;
  // a write commits only while no response is pending, so one write is in flight
  assign wr_commit = aw_now && w_now && !bvalid_q;
  assign wr_hit = hits_ctrl(wr_addr);
  // register lives in byte lane 0; a write without that lane changes nothing
  assign reg_wr = wr_commit && wr_hit && wr_strb[0];

  // holding flags clear on commit; a half taken early waits for its partner
  assign aw_have_d = wr_commit ? 1'b0 : aw_now;
  assign w_have_d = wr_commit ? 1'b0 : w_now;
  // capture on every fire; a capture in the commit cycle is simply never used
  assign wreq_d = {aw_fire ? s_axi_awaddr : wreq_q.addr,
    w_fire ? s_axi_wdata : wreq_q.data,
    w_fire ? s_axi_wstrb : wreq_q.strb};

  // response raised by the commit, dropped when the master takes it
  assign bvalid_d = wr_commit || (bvalid_q && !b_done);
  assign bresp_d = wr_commit ? resp_for(wr_hit) : bresp_q;

  // read answer: unmapped words give slverr with zero data
  assign rd_hit = hits_ctrl(s_axi_araddr);
  assign rd_word = rd_hit ? {24'h00_0000, ctrl_value} : 32'h0000_0000;
  assign rvalid_d = ar_fire || (rvalid_q && !r_done);
  assign rdata_d = ar_fire ? rd_word : rdata_q;
  assign rresp_d = ar_fire ? resp_for(rd_hit) : rresp_q;

  // write holding registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      wreq_q <= '0;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      wreq_q <= wreq_d;
    end
  end

  // write response registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= `PMS_RESP_OKAY;
    end
    else
    begin
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  // read response registers; data stands until the master takes it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `PMS_RESP_OKAY;
    end
    else
    begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // the register itself; reserved positions never store a one
  pms_ctrl_reg u_ctrl (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(reg_wr),
    .wr_data(wr_data[7:0]),
    .value(ctrl_value),
    .standby(standby)
  );

  // write answer outputs
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // read answer outputs
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // requests follow the register directly; clearing releases the module next cycle
  assign second_serial_standby_bit = standby.serial;
  assign interval_timer_standby_bit = standby.itimer;
  assign multifunction_timer_standby_bit = standby.mftimer;

endmodule // pms_standby_ctrl

// ==== verif/pms_standby_ctrl_props.sv ====
// checker for the standby control register block
// assumes binding into pms_standby_ctrl
`timescale 1ns/100ps
module pms_standby_ctrl_props (
  // clock, reset and bus answers
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  // standby requests
  input wire logic second_serial_standby_bit,
  input wire logic interval_timer_standby_bit,
  input wire logic multifunction_timer_standby_bit
);
  wire [2:0] sb = {second_serial_standby_bit, interval_timer_standby_bit,
    multifunction_timer_standby_bit};
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // requests move only at a write commit; the edge after reset is exempt
  chk_serial_commit:
    assert property ($past(aresetn) && $changed(sb[2]) |-> $rose(s_axi_bvalid)) else $error("b7");
  chk_itimer_commit:
    assert property ($past(aresetn) && $changed(sb[1]) |-> $rose(s_axi_bvalid)) else $error("b4");
  chk_mftimer_commit:
    assert property ($past(aresetn) && $changed(sb[0]) |-> $rose(s_axi_bvalid)) else $error("b1");
  chk_reserved_zero:
    assert property (s_axi_rvalid |-> !s_axi_rdata[6:5] && !s_axi_rdata[3:2]) else $error("rsv");
  chk_bit0_zero:
    assert property (s_axi_rvalid |-> !s_axi_rdata[0]) else $error("b0");
  chk_image_match:
    assert property ($rose(s_axi_rvalid) && !s_axi_rresp |->
      {s_axi_rdata[7], s_axi_rdata[4], s_axi_rdata[1]} == $past(sb)) else $error("image");
endmodule // pms_standby_ctrl_props
bind pms_standby_ctrl pms_standby_ctrl_props u_props (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_bvalid(s_axi_bvalid),
  .second_serial_standby_bit(second_serial_standby_bit),
  .interval_timer_standby_bit(interval_timer_standby_bit),
  .multifunction_timer_standby_bit(multifunction_timer_standby_bit)
);

// ==== verif/test_pms_standby_ctrl.sv ====
// axi4-lite bench for the standby block
// assumes design and checker compiled first
`timescale 1ns/100ps
module test_pms_standby_ctrl;
  // bus side; answer readies stay high
  logic aclk = '0, aresetn = '0, s_axi_bready = '1, s_axi_rready = '1, ta, tw, td;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_arvalid = '0, s_axi_awready;
  logic s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] v;
  logic [3:0] lane = 4'h1;
  wire [2:0] sb;
  int fail_count = 0, cmp_count = 0;
  pms_standby_ctrl u_dut (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .second_serial_standby_bit(sb[2]),
    .interval_timer_standby_bit(sb[1]),
    .multifunction_timer_standby_bit(sb[0])
  );
  // 8 ns clock
  initial forever #4 aclk = ~aclk;
  task automatic chk(input logic [33:0] s, e);
    cmp_count++;
    fail_count += (s !== e);
    if (s !== e)
      $display("Error %0t: got %h not %h", $time, s, e);
  endtask
  // one access, held until taken; junk upper write bytes must be ignored
  task automatic acc(input logic w, logic [11:0] a, logic [7:0] d, logic [1:0] r);
    {s_axi_awaddr, s_axi_araddr} <= {a, a};
    s_axi_wdata <= {24'hffffff, d};
    s_axi_wstrb <= lane;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {w, w, !w};
    do
    begin
      @(negedge aclk);
      ta = w ? s_axi_awready : s_axi_arready;
      tw = w & s_axi_wready;
      td = w ? s_axi_bvalid : s_axi_rvalid;
      if (td)
        chk({w ? s_axi_bresp : s_axi_rresp, w ? 32'h0 : s_axi_rdata},
          {r, 24'h0, w ? 8'h0 : d});
      @(posedge aclk);
      if (ta)
        {s_axi_awvalid, s_axi_arvalid} <= '0;
      if (tw)
        s_axi_wvalid <= '0;
    end while (!td);
  endtask
  task complete_run;
    $display("compares %0d errors %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, far past the ~60 cycles needed
  initial
  begin
    repeat (3000) @(posedge aclk);
    fail_count++;
    complete_run();
  end
  // walk each bit, then all ones and an unmapped word
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= '1;
    @(posedge aclk);
    acc(0, 12'h000, 8'h00, 2'h0);
    chk(sb, 3'h0);
    for (int i = 0; i < 8; i++)
    begin
      v = 8'h01 << i;
      acc(1, 12'h000, v, 2'h0);
      acc(0, 12'h000, v & 8'h92, 2'h0);
      chk(sb, {v[7], v[4], v[1]});
    end
    acc(1, 12'h000, 8'hff, 2'h0);
    // a write without byte lane 0 is answered okay and leaves the register alone
    lane = 4'h0;
    acc(1, 12'h000, 8'h00, 2'h0);
    lane = 4'h1;
    acc(1, 12'h004, 8'h00, 2'h2);
    acc(0, 12'h004, 8'h00, 2'h2);
    acc(0, 12'h000, 8'h92, 2'h0);
    chk(sb, 3'h7);
    // a reset in mid-run clears every request, with no transfer in flight
    aresetn <= '0;
    repeat (3) @(posedge aclk);
    aresetn <= '1;
    @(posedge aclk);
    chk(sb, 3'h0);
    acc(0, 12'h000, 8'h00, 2'h0);
    complete_run();
  end
endmodule // test_pms_standby_ctrl
